// >>> rtl/clk_mode_pkg.sv
// constants shared by the dual clock mode controller
package clk_mode_pkg;
  // ****************************************
  // port addresses
  // ****************************************
  localparam logic [4:0] STATUS_PORT_ADDR = 5'h0_e; // clock status input port
  localparam logic [4:0] COMMAND_PORT_ADDR = 5'h1_6; // clock command output port
  // ****************************************
  // field positions
  // ****************************************
  localparam int ACTIVE_MODE_BIT = 0; // status: 1 = slow mode running
  localparam int LOW_STABLE_BIT = 1; // status: low clock stable
  localparam int SLOW_SEL_BIT = 2; // command: 1 = request slow mode
  localparam int WARMUP_LSB = 0; // command: warm-up select low bit
  localparam int WARMUP_MSB = 1; // command: warm-up select high bit
  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [3:0] COMMAND_RESET = 4'h0; // normal mode, shortest warm-up
  localparam int STABLE_COUNT_BITS = 4; // counter bits, low clock called stable after 2**bits slow ticks
  localparam int SLOW_DIV = 4; // core cycles per slow tick, default model
  localparam int WARMUP_BASE_BITS = 4; // slow ticks of shortest warm-up = 2**bits
endpackage

// >>> rtl/dual_clock_mode_controller.sv
// dual clock mode controller: normal/slow selection, warm-up and status port
// Behaviour
// - two modes, fast normal and slow
// - both oscillators start, normal mode follows
// - fast oscillator stops on slow command
// - mode requested through command port 16h
// - status readable through input port 0Eh
// - any reset selects normal mode
// - status bit 0 shows active mode
// - command bit 2 set enters slow mode
// - stay slow until warm-up expires
// - 4096Hz timer rates blocked in slow
// - low-clock users invalid until oscillation stable
`timescale 1ns/1ps
module dual_clock_mode_controller #(
  parameter int SLOW_DIV = clk_mode_pkg::SLOW_DIV,
  parameter int STABLE_BITS = clk_mode_pkg::STABLE_COUNT_BITS,
  parameter int WARMUP_BITS = clk_mode_pkg::WARMUP_BASE_BITS
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // port access from the core
  input wire logic [4:0] PORT_ADDR_IN,
  input wire logic [3:0] PORT_WDATA_IN,
  input wire logic PORT_WR_IN,
  input wire logic PORT_RD_IN,
  output logic [3:0] PORT_RDATA_OUT,
  // oscillator control
  output logic FAST_OSC_EN_OUT,
  output logic SLOW_OSC_EN_OUT,
  output logic CORE_CLK_SEL_OUT,
  // peripheral gating
  output logic RATE_4096_OK_OUT,
  output logic LOW_CLOCK_OK_OUT
);
  // ****************************************
  // mode state
  // ****************************************
  typedef enum logic [1:0] {ST_NORMAL, ST_TO_SLOW, ST_SLOW, ST_WARMUP} mode_e;
  mode_e state_reg, state_next; // mode sequencer
  logic slow_tick; // low clock tick enable
  logic warm_done; // warm-up elapsed
  logic warm_start; // start warm-up counter
  logic [STABLE_BITS:0] stab_reg; // low clock settling counter
  logic low_stable; // settling finished
  logic [1:0] warm_sel_reg; // latched warm-up select
  logic active_slow_reg; // status: slow mode running
  logic sel_slow_reg; // core clock source select
  logic fast_en_reg; // fast oscillator enable
  logic cmd_wr; // command port write
  logic st_rd; // status port read
  logic [3:0] status_word; // status port view
  logic [1:0] warm_sel_now; // select seen by the timer as it loads
  logic [19:0] warm_cyc_reg; // core cycles spent in warm-up, check helper
  // longest legal warm-up in core cycles, with slack for tick phase
  localparam int WARM_MAX = (1 << (WARMUP_BITS + 6)) * SLOW_DIV + SLOW_DIV + 4;
  // slow request bit of a command word, decoded in several places
  function automatic logic slow_req(input logic [3:0] data);
    return data[clk_mode_pkg::SLOW_SEL_BIT];
  endfunction
  assign cmd_wr = PORT_WR_IN && (PORT_ADDR_IN == clk_mode_pkg::COMMAND_PORT_ADDR);
  assign st_rd = PORT_RD_IN && (PORT_ADDR_IN == clk_mode_pkg::STATUS_PORT_ADDR);
  assign low_stable = stab_reg[STABLE_BITS];
  // ****************************************
  // low clock tick and warm-up timer
  // ****************************************
  slow_tick_gen #(.DIV(SLOW_DIV)) u_tick (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .tick_out(slow_tick)
  );
  warmup_timer #(.BASE_BITS(WARMUP_BITS)) u_warm (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .start_in(warm_start),
    .sel_in(warm_sel_now),
    .tick_in(slow_tick),
    .done_out(warm_done)
  );
  // ****************************************
  // sequencer
  // ****************************************
  // warm-up starts on a return request in slow mode
  assign warm_start = (state_reg == ST_SLOW) && cmd_wr
    && !slow_req(PORT_WDATA_IN);
  // the latch takes the field on the same edge as the load, so the
  // timer must see the field straight from the command word
  assign warm_sel_now = warm_start
    ? PORT_WDATA_IN[clk_mode_pkg::WARMUP_MSB:clk_mode_pkg::WARMUP_LSB]
    : warm_sel_reg;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_NORMAL: begin
        if (cmd_wr && slow_req(PORT_WDATA_IN)) begin
          state_next = ST_TO_SLOW;
        end
      end
      ST_TO_SLOW: begin
        // switch at a slow tick so the new source starts cleanly
        if (slow_tick) begin
          state_next = ST_SLOW;
        end
      end
      ST_SLOW: begin
        if (warm_start) begin
          state_next = ST_WARMUP;
        end
      end
      ST_WARMUP: begin
        if (warm_done) begin
          state_next = ST_NORMAL;
        end
      end
    endcase
  end
  // state register, reset lands in normal mode
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_reg <= ST_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end
  // ****************************************
  // oscillator settling and warm-up select
  // ****************************************
  // settling counter runs on slow ticks after power-up
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      stab_reg <= '0;
    end else if (slow_tick && !low_stable) begin
      stab_reg <= stab_reg + (STABLE_BITS+1)'(1);
    end
  end
  // warm-up select latched from every command write
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      warm_sel_reg <= 2'h0;
    end else if (cmd_wr) begin
      warm_sel_reg <= PORT_WDATA_IN[clk_mode_pkg::WARMUP_MSB:clk_mode_pkg::WARMUP_LSB];
    end
  end
  // ****************************************
  // clock source, fast oscillator, status
  // ****************************************
  // source and status move together, only on the switching edge
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sel_slow_reg <= 1'b0;
      active_slow_reg <= 1'b0;
      fast_en_reg <= 1'b1;
    end else begin
      if (state_reg == ST_TO_SLOW && slow_tick) begin
        sel_slow_reg <= 1'b1;
        active_slow_reg <= 1'b1;
      end else if (state_reg == ST_WARMUP && warm_done) begin
        sel_slow_reg <= 1'b0;
        active_slow_reg <= 1'b0;
      end
      // fast oscillator off in slow, back on for warm-up
      if (state_next == ST_SLOW) begin
        fast_en_reg <= 1'b0;
      end else if (state_next == ST_WARMUP) begin
        fast_en_reg <= 1'b1;
      end
    end
  end
  assign status_word = {2'b00, low_stable, active_slow_reg};
  // registered outputs
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PORT_RDATA_OUT <= 4'h0;
      FAST_OSC_EN_OUT <= 1'b1;
      SLOW_OSC_EN_OUT <= 1'b0;
      CORE_CLK_SEL_OUT <= 1'b0;
      RATE_4096_OK_OUT <= 1'b0;
      LOW_CLOCK_OK_OUT <= 1'b0;
    end else begin
      PORT_RDATA_OUT <= st_rd ? status_word : 4'h0;
      FAST_OSC_EN_OUT <= fast_en_reg;
      SLOW_OSC_EN_OUT <= 1'b1;
      CORE_CLK_SEL_OUT <= sel_slow_reg;
      RATE_4096_OK_OUT <= !active_slow_reg && low_stable;
      LOW_CLOCK_OK_OUT <= low_stable;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  a_slow_cmd_move: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_NORMAL && cmd_wr && slow_req(PORT_WDATA_IN))
    |=> state_reg == ST_TO_SLOW)
    else $error("slow command not taken");
  a_fast_stops: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_SLOW) |-> !fast_en_reg)
    else $error("fast oscillator running in slow mode");
  a_status_follows: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    CORE_CLK_SEL_OUT == $past(active_slow_reg))
    else $error("status differs from clock source");
  a_warm_holds: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_WARMUP && !warm_done) |=> sel_slow_reg)
    else $error("left slow clock before warm-up end");
  a_warm_ends: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_WARMUP && warm_done) |=> state_reg == ST_NORMAL && !sel_slow_reg)
    else $error("warm-up end did not restore normal");
  a_status_read: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    st_rd |=> PORT_RDATA_OUT == $past(status_word))
    else $error("status read wrong");
  a_rate_block: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    active_slow_reg |=> !RATE_4096_OK_OUT)
    else $error("4096 rate allowed in slow mode");
  a_switch_tick: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    $rose(sel_slow_reg) |-> $past(slow_tick))
    else $error("switch not aligned to slow tick");
  a_warm_fast_on: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_WARMUP) |-> fast_en_reg)
    else $error("fast oscillator off during warm-up");
  // cycles spent in warm-up, for the length bound below
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      warm_cyc_reg <= 20'h0_0000;
    end else if (state_reg == ST_WARMUP) begin
      warm_cyc_reg <= warm_cyc_reg + 20'h0_0001;
    end else begin
      warm_cyc_reg <= 20'h0_0000;
    end
  end
  // warm-up never outlasts the longest select choice
  a_warm_bound: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    warm_cyc_reg <= 20'(WARM_MAX))
    else $error("warm-up longer than longest select");
  // fast oscillator pin low one cycle into slow mode
  a_fast_pin_off: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_SLOW) |=> !FAST_OSC_EN_OUT)
    else $error("fast oscillator pin high in slow mode");
  // slow oscillator enabled once out of reset
  a_slow_osc_on: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    1'b1 |=> SLOW_OSC_EN_OUT)
    else $error("slow oscillator not enabled");
  // clock source follows the mode states
  a_mode_decode: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    sel_slow_reg == (state_reg == ST_SLOW || state_reg == ST_WARMUP))
    else $error("clock source does not match mode");
  // return command starts warm-up
  a_warm_enter: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    warm_start |=> state_reg == ST_WARMUP)
    else $error("return command did not start warm-up");
  // warm-up stays until the timer ends it
  a_no_early_normal: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_WARMUP && !warm_done) |=> state_reg == ST_WARMUP)
    else $error("warm-up left early");
  // slow mode holds without a return command
  a_slow_hold: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_SLOW && !warm_start) |=> state_reg == ST_SLOW)
    else $error("slow mode left without command");
  // no switch between slow ticks
  a_to_slow_wait: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_TO_SLOW && !slow_tick) |=> state_reg == ST_TO_SLOW && !sel_slow_reg)
    else $error("switched between slow ticks");
  // fast oscillator runs in normal mode
  a_normal_fast: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_NORMAL) |-> fast_en_reg)
    else $error("fast oscillator off in normal mode");
  // low clock users held off until settled
  a_low_ok_pin: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !low_stable |=> !LOW_CLOCK_OK_OUT)
    else $error("low clock reported before settling");
  // settled flag only drops with reset
  a_stab_hold: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    low_stable |=> low_stable)
    else $error("low clock settled flag dropped");
  // 4096 rate back in normal once settled
  a_rate_normal: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (!active_slow_reg && low_stable) |=> RATE_4096_OK_OUT)
    else $error("4096 rate blocked in normal mode");
  // read data is zero outside reads
  a_read_idle: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !st_rd |=> PORT_RDATA_OUT == 4'h0)
    else $error("read data outside a read");
  // unused status bits read zero
  a_status_top: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    PORT_RDATA_OUT[3:2] == 2'b00)
    else $error("unused status bits set");
  // other writes leave normal mode alone
  a_cmd_ignored: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (!cmd_wr && state_reg == ST_NORMAL) |=> state_reg == ST_NORMAL)
    else $error("normal mode left without command");
  // fast oscillator pin high through warm-up
  a_warm_fast_pin: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (state_reg == ST_WARMUP) |=> FAST_OSC_EN_OUT)
    else $error("fast oscillator pin low in warm-up");
  // status bit 0 carries the active mode
  a_rdata_mode: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    st_rd |=> PORT_RDATA_OUT[0] == $past(active_slow_reg))
    else $error("status mode bit wrong");
  // status bit 1 carries the settled flag
  a_rdata_stable: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    st_rd |=> PORT_RDATA_OUT[1] == $past(low_stable))
    else $error("status stable bit wrong");
endmodule

// >>> rtl/slow_tick_gen.sv
// divider that turns the core clock into the low-clock tick enable
`timescale 1ns/1ps
module slow_tick_gen #(
  parameter int DIV = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // tick out
  output logic tick_out
);
  logic [15:0] cnt_reg; // divider count
  logic wrap; // last count of a period
  assign wrap = (cnt_reg == 16'(DIV - 1));
  // free running divider, one pulse per period
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= 16'h0000;
      tick_out <= 1'b0;
    end else begin
      cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
      tick_out <= wrap;
    end
  end
endmodule

// >>> rtl/warmup_timer.sv
// warm-up counter timed by low clock ticks
`timescale 1ns/1ps
module warmup_timer #(
  parameter int BASE_BITS = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // control
  input wire logic start_in,
  input wire logic [1:0] sel_in,
  input wire logic tick_in,
  // result
  output logic done_out
);
  localparam int W = BASE_BITS + 7; // enough for the longest choice
  logic [W-1:0] cnt_reg; // ticks still to wait
  logic running_reg; // warm-up in progress
  logic [W-1:0] load_val; // length picked by the select field
  // each select step multiplies by 4: 2^b, 2^(b+2), 2^(b+4), 2^(b+6)
  assign load_val = W'(1) << (BASE_BITS + 2 * int'(sel_in));
  // count down on slow ticks only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= '0;
      running_reg <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt_reg <= load_val;
        running_reg <= 1'b1;
      end else if (running_reg && tick_in) begin
        if (cnt_reg == W'(1)) begin
          running_reg <= 1'b0;
          done_out <= 1'b1;
        end
        cnt_reg <= cnt_reg - W'(1);
      end
    end
  end
endmodule

// >>> tb/dual_clock_mode_controller_tb.sv
// self-checking bench for the dual clock mode controller
`timescale 1ns/1ps
module dual_clock_mode_controller_tb;
  // ****************************************
  // bench signals
  // ****************************************
  localparam int DIV = 2; // core cycles per slow tick
  localparam int WB = 2; // shortest warm-up exponent
  logic clk = 0; // core clock
  logic arst_n = 0; // reset, active low
  logic [4:0] addr = 5'h0_0; // port address
  logic [3:0] wdata = 4'h0; // write data
  logic wr = 0; // write strobe
  logic rd = 0; // read strobe
  logic [3:0] rdata, st; // read data and last status read
  logic fast_en, slow_en, clk_sel, rate_ok, low_ok, fast_run; // observed outputs
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0; // cycle counter for the hang guard
  int n; // wait counter
  int exp_cyc; // expected warm-up cycles
  always #4 clk = ~clk;
  dual_clock_mode_controller #(.SLOW_DIV(DIV), .STABLE_BITS(2), .WARMUP_BITS(WB)) dut_u (
    .CLK_IN(clk), .ARST_N_IN(arst_n), .PORT_ADDR_IN(addr), .PORT_WDATA_IN(wdata),
    .PORT_WR_IN(wr), .PORT_RD_IN(rd), .PORT_RDATA_OUT(rdata), .FAST_OSC_EN_OUT(fast_en),
    .SLOW_OSC_EN_OUT(slow_en), .CORE_CLK_SEL_OUT(clk_sel), .RATE_4096_OK_OUT(rate_ok),
    .LOW_CLOCK_OK_OUT(low_ok));
  osc_pair_model osc_u (.clk_in(clk), .fast_en_in(fast_en), .slow_en_in(slow_en),
    .fast_run_out(fast_run), .slow_run_out());
  // ****************************************
  // tasks
  // ****************************************
  // compare and count
  task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // one write strobe cycle
  task automatic port_wr(input logic [4:0] a, input logic [3:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  // one read strobe cycle, data taken in the following cycle
  task automatic port_rd(input logic [4:0] a);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    st = rdata;
  endtask
  // bounded wait for the core clock select
  task automatic wait_sel(input logic v);
    n = 0;
    while (clk_sel !== v && n < 4000) begin
      @(negedge clk);
      n++;
    end
  endtask
  // verdict and stop
  task automatic end_of_test;
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1;
    @(negedge clk);
    check(fast_en, 4'h1, "fast_en");
    check(slow_en, 4'h1, "slow_en");
    check(clk_sel, 4'h0, "clk_sel");
    // poll the stable flag before asking for slow mode
    n = 0;
    st = 4'h0;
    while (st[1] !== 1'b1 && n < 200) begin
      port_rd(clk_mode_pkg::STATUS_PORT_ADDR);
      n++;
    end
    check(st, 4'h2, "status");
    check(low_ok, 4'h1, "low_ok");
    check(rate_ok, 4'h1, "rate_ok");
    port_rd(5'h0_f);
    check(st, 4'h0, "unmapped read");
    port_wr(5'h1_5, 4'h4);
    repeat (8) @(negedge clk);
    check(clk_sel, 4'h0, "clk_sel");
    // every warm-up select, each after a trip into slow mode
    for (int s = 0; s < 4; s++) begin
      port_wr(clk_mode_pkg::COMMAND_PORT_ADDR, 4'h4);
      @(negedge clk); // idle slot for the no-op
      wait_sel(1'b1);
      check(n <= DIV + 2, 4'h1, "slow switch time");
      check(fast_en, 4'h0, "fast_en");
      check(fast_run, 4'h0, "fast_run");
      check(rate_ok, 4'h0, "rate_ok");
      port_rd(clk_mode_pkg::STATUS_PORT_ADDR);
      check(st, 4'h3, "status");
      port_wr(clk_mode_pkg::COMMAND_PORT_ADDR, 4'(s));
      repeat (2) @(negedge clk);
      check(fast_en, 4'h1, "fast_en");
      exp_cyc = (1 << (WB + 2 * s)) * DIV;
      wait_sel(1'b0);
      check(n + DIV + 3 >= exp_cyc, 4'h1, "warm-up short");
      check(n <= exp_cyc + DIV + 3, 4'h1, "warm-up long");
      port_rd(clk_mode_pkg::STATUS_PORT_ADDR);
      check(st, 4'h2, "status");
    end
    // reset in mid-run from slow mode
    port_wr(clk_mode_pkg::COMMAND_PORT_ADDR, 4'h4);
    wait_sel(1'b1);
    arst_n = 0;
    @(negedge clk);
    check(clk_sel, 4'h0, "clk_sel");
    check(fast_en, 4'h1, "fast_en");
    arst_n = 1;
    @(negedge clk);
    check(slow_en, 4'h1, "slow_en");
    check(low_ok, 4'h0, "low_ok");
    check(rate_ok, 4'h0, "rate_ok");
    port_rd(clk_mode_pkg::STATUS_PORT_ADDR);
    check(st, 4'h0, "status");
    end_of_test();
  end
endmodule

// >>> tb/osc_pair_model.sv
// behavioural model of the fast and slow crystal oscillators
`timescale 1ns/1ps
module osc_pair_model #(
  parameter int START_CYC = 3
) (
  // clock and enables
  input wire logic clk_in,
  input wire logic fast_en_in,
  input wire logic slow_en_in,
  // running flags
  output logic fast_run_out,
  output logic slow_run_out
);
  // ****************************************
  // oscillator behaviour
  // ****************************************
  int fast_cnt = 0; // fast crystal start-up count
  // fast crystal dies at once when disabled, restarts after a short start-up
  always @(posedge clk_in) begin
    fast_cnt <= fast_en_in ? ((fast_cnt < START_CYC) ? fast_cnt + 1 : fast_cnt) : 0;
  end
  assign fast_run_out = fast_en_in && (fast_cnt == START_CYC);
  // slow crystal runs whenever enabled
  assign slow_run_out = slow_en_in;
endmodule
